/* File: design/asp_pkg.sv */
/*
 audio sample packetizer: shared constants.
 assumes: both ends and the bench compile this first.
*/
package asp_pkg;
   // =============================================
   // bus widths
   localparam int unsigned DATA_W = 256; // audio bus
   localparam int unsigned WORD_W = 32;  // one channel word
   localparam int unsigned VAL_W  = 20;  // time stamp, divider
   // =============================================
   // layout select codes, low four bits
   localparam logic [3:0] FMT_LPCM = 4'h0;
   localparam logic [3:0] FMT_3D   = 4'h4;
   localparam logic [3:0] FMT_MST  = 4'h6;
   localparam int unsigned FIRST_BEAT_BIT = 4; // 3D first write
   // =============================================
   // packet types
   localparam logic [7:0] TYPE_ACR  = 8'h01;
   localparam logic [7:0] TYPE_LPCM = 8'h02;
   localparam logic [7:0] TYPE_3D   = 8'h0B;
   localparam logic [7:0] TYPE_MST  = 8'h0E;
   // =============================================
   // word fields and counts
   localparam int unsigned SP_BIT      = 31; // sample present flag
   localparam logic [2:0]  COUNT_FULL  = 3'h4; // four samples
   localparam int unsigned ACR_SHIFT   = 7;  // divider / 128
   localparam int unsigned ACR_DIV_LSB = 32; // divider in body
   // =============================================
   // source end register map (byte addresses)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_CTS    = 8'h04;
   localparam logic [7:0] REG_DIV    = 8'h08;
   localparam logic [7:0] REG_SEND   = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_WORD0  = 8'h20;
   localparam int unsigned CTRL_HOLD_BIT = 8;
   localparam logic [19:0] RST_DIV = 20'h01800;
endpackage : asp_pkg

/* File: design/asp_if.sv */
/*
 audio sample packetizer: link between source logic and device.
 assumes: both ends share CLK; the bench ties them together.
*/
`timescale 1ns/1ps
`default_nettype none
interface asp_if;
   logic [255:0] audio_data;           // eight channel words
   logic         audio_word_qualifier; // beat valid
   logic [4:0]   layout_select;        // format, bit 4 first beat
   logic [19:0]  cycle_time_stamp;     // clock regen time stamp
   logic [19:0]  divider;              // clock regen divider
   // =============================================
   // the documented device end
   modport device (
      input audio_data,
      input audio_word_qualifier,
      input layout_select,
      input cycle_time_stamp,
      input divider
   );
   // =============================================
   // the upstream source end
   modport source (
      output audio_data,
      output audio_word_qualifier,
      output layout_select,
      output cycle_time_stamp,
      output divider
   );
endinterface : asp_if
`default_nettype wire

/* File: design/asp_device.sv */
/*
 audio sample packetizer, device end: queues qualified audio
 beats, builds sample packets, schedules clock regen packets.
 assumes: one clock; slot strobes come from the packet stream
 arbiter and mean the packet bus is free that cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_device #(
   parameter int unsigned SAMPLES_MAX = 4 // samples per packet
) (
   // clock and reset
   input  wire logic         CLK,
   input  wire logic         RST_N,
   // audio from the source logic
   asp_if.device             AUD,
   // configuration and slot strobes
   input  wire logic         FRL_OPTION,
   input  wire logic         LINK_SLOT,
   input  wire logic         VIDEO_SLOT,
   // auxiliary packets in
   input  wire logic         AUX_IN_VALID,
   input  wire logic [7:0]   AUX_IN_TYPE,
   input  wire logic [255:0] AUX_IN_BODY,
   // packets out
   output logic              PKT_VALID,
   output logic [7:0]        PKT_TYPE,
   output logic              PKT_LAYOUT,
   output logic [3:0]        PKT_PRESENT,
   output logic [1:0]        PKT_INDEX,
   output logic [255:0]      PKT_BODY,
   // auxiliary packets out
   output logic              AUX_OUT_VALID,
   output logic [7:0]        AUX_OUT_TYPE,
   output logic [255:0]      AUX_OUT_BODY,
   // status
   output logic              OVERRUN
);
   // =============================================
   // state
   typedef struct packed {
      logic         q_valid;    // queue entry holds a beat
      logic [255:0] q_data;     // queued audio words
      logic [4:0]   q_fmt;      // layout select of the beat
      logic [255:0] body;       // packet under assembly
      logic [2:0]   count;      // samples in packet
      logic [7:0]   ptype;      // type of packet under assembly
      logic         layout;     // wide layout flag
      logic [3:0]   present;    // per pair present bits
      logic [1:0]   index;      // 3D beat index in packet
      logic [1:0]   beat3d;     // last 3D beat index
      logic [19:0]  acr_cnt;    // samples since last regen
      logic         acr_pend;   // regen packet waiting
      logic         pkt_valid;  // output registers follow
      logic [7:0]   pkt_type;
      logic         pkt_layout;
      logic [3:0]   pkt_present;
      logic [1:0]   pkt_index;
      logic [255:0] pkt_body;
      logic         aux_valid;
      logic [7:0]   aux_type;
      logic [255:0] aux_body;
      logic         overrun;
   } asp_dev_state_type;

   asp_dev_state_type state_reg;  // registered state
   asp_dev_state_type state_next; // its next value

   // =============================================
   // helpers
   // zero every word whose present flag is low
   function automatic logic [255:0] asp_mask(
      input logic [255:0] d);
      logic [255:0] m;
      m = '0;
      for (int i = 0; i < 8; i++) begin
         if (d[i*32 + asp_pkg::SP_BIT]) begin
            m[i*32 +: 32] = d[i*32 +: 32];
         end
      end
      return m;
   endfunction : asp_mask

   // present flag of each channel word
   function automatic logic [7:0] asp_sp(
      input logic [255:0] d);
      logic [7:0] s;
      s = '0;
      for (int i = 0; i < 8; i++) begin
         s[i] = d[i*32 + asp_pkg::SP_BIT];
      end
      return s;
   endfunction : asp_sp

   // one present bit per channel pair or stream
   function automatic logic [3:0] asp_pairs(
      input logic [7:0] s);
      logic [3:0] p;
      p = '0;
      for (int i = 0; i < 4; i++) begin
         p[i] = s[2*i] | s[2*i+1];
      end
      return p;
   endfunction : asp_pairs

   // =============================================
   // next state
   // one pass: emit on a slot, then take from the queue,
   // then refill the queue from the bus
   always_comb begin
      logic         slot;    // packet bus free this cycle
      logic         consume; // queue entry used up
      logic         sample;  // accepted beat starts a sample
      logic [3:0]   fmt;     // low layout bits of queue entry
      logic [7:0]   sp;      // present flags of queue entry
      logic [255:0] m;       // masked queue entry
      logic [19:0]  limit;   // samples per regen interval
      slot    = 1'b0;
      consume = 1'b0;
      sample  = 1'b0;
      fmt     = state_reg.q_fmt[3:0];
      sp      = asp_sp(state_reg.q_data);
      m       = asp_mask(state_reg.q_data);
      limit   = AUD.divider >> asp_pkg::ACR_SHIFT;
      state_next = state_reg;
      state_next.pkt_valid = 1'b0;
      state_next.overrun   = 1'b0;
      // the queue drains on the clock side picked by the option
      slot = FRL_OPTION ? VIDEO_SLOT : LINK_SLOT;

      // emit: clock regen first, it is the rarer and timed one
      if (slot && state_reg.acr_pend) begin
         state_next.pkt_valid   = 1'b1;
         state_next.pkt_type    = asp_pkg::TYPE_ACR;
         state_next.pkt_layout  = 1'b0;
         state_next.pkt_present = 4'h0;
         state_next.pkt_index   = 2'h0;
         state_next.pkt_body    = '0;
         state_next.pkt_body[19:0] = AUD.cycle_time_stamp;
         state_next.pkt_body[asp_pkg::ACR_DIV_LSB +: 20] =
            AUD.divider;
         state_next.acr_pend = 1'b0;
      end else if (slot && state_reg.count != 3'h0) begin
         // any collected samples leave at once
         state_next.pkt_valid   = 1'b1;
         state_next.pkt_type    = state_reg.ptype;
         state_next.pkt_layout  = state_reg.layout;
         state_next.pkt_present = state_reg.present;
         state_next.pkt_index   = state_reg.index;
         state_next.pkt_body    = state_reg.body;
         state_next.count       = 3'h0;
      end

      // take the queued beat into the packet
      if (state_reg.q_valid) begin
         case (fmt)
            asp_pkg::FMT_LPCM: begin
               if (|sp[7:2]) begin
                  // wide layout: one sample fills a packet
                  if (state_next.count == 3'h0) begin
                     state_next.body    = m;
                     state_next.count   = asp_pkg::COUNT_FULL;
                     state_next.ptype   = asp_pkg::TYPE_LPCM;
                     state_next.layout  = 1'b1;
                     state_next.present = asp_pairs(sp);
                     state_next.index   = 2'h0;
                     consume = 1'b1;
                  end
               end else if (state_next.count == 3'h0 ||
                  (!state_next.layout &&
                   state_next.ptype == asp_pkg::TYPE_LPCM &&
                   state_next.count < SAMPLES_MAX[2:0])) begin
                  // two channel layout: stack samples
                  if (state_next.count == 3'h0) begin
                     state_next.body    = '0;
                     state_next.present = 4'h0;
                  end
                  state_next.body[{state_next.count[1:0], 6'h00}
                     +: 64] = m[63:0];
                  state_next.present[state_next.count[1:0]] =
                     |sp[1:0];
                  state_next.count  = state_next.count + 3'h1;
                  state_next.ptype  = asp_pkg::TYPE_LPCM;
                  state_next.layout = 1'b0;
                  state_next.index  = 2'h0;
                  consume = 1'b1;
               end
            end
            asp_pkg::FMT_3D: begin
               // each write of eight channels is one part
               if (state_next.count == 3'h0) begin
                  state_next.body    = m;
                  state_next.count   = asp_pkg::COUNT_FULL;
                  state_next.ptype   = asp_pkg::TYPE_3D;
                  state_next.layout  = 1'b1;
                  state_next.present = asp_pairs(sp);
                  // first write restarts the part index
                  state_next.index =
                     state_reg.q_fmt[asp_pkg::FIRST_BEAT_BIT] ?
                     2'h0 : state_reg.beat3d + 2'h1;
                  state_next.beat3d = state_next.index;
                  consume = 1'b1;
               end
            end
            asp_pkg::FMT_MST: begin
               // one stereo pair per stream, idle streams absent
               if (state_next.count == 3'h0) begin
                  state_next.body    = m;
                  state_next.count   = asp_pkg::COUNT_FULL;
                  state_next.ptype   = asp_pkg::TYPE_MST;
                  state_next.layout  = 1'b0;
                  state_next.present = asp_pairs(sp);
                  state_next.index   = 2'h0;
                  consume = 1'b1;
               end
            end
            default: begin
               // reserved layout: the beat is dropped
               consume = 1'b1;
            end
         endcase
      end
      if (consume) begin
         state_next.q_valid = 1'b0;
      end

      // refill the queue; a full queue loses the beat
      if (AUD.audio_word_qualifier) begin
         if (!state_next.q_valid) begin
            state_next.q_valid = 1'b1;
            state_next.q_data  = AUD.audio_data;
            state_next.q_fmt   = AUD.layout_select;
            sample = (AUD.layout_select[3:0] != asp_pkg::FMT_3D) ||
               AUD.layout_select[asp_pkg::FIRST_BEAT_BIT];
         end else begin
            state_next.overrun = 1'b1;
         end
      end

      // regen interval counted in samples, set wins over send
      if (sample) begin
         if (state_reg.acr_cnt + 20'h1 >= limit) begin
            state_next.acr_cnt  = 20'h0;
            state_next.acr_pend = 1'b1;
         end else begin
            state_next.acr_cnt = state_reg.acr_cnt + 20'h1;
         end
      end

      // auxiliary stream is forwarded untouched
      state_next.aux_valid = AUX_IN_VALID;
      state_next.aux_type  = AUX_IN_TYPE;
      state_next.aux_body  = AUX_IN_BODY;
   end

   // =============================================
   // state register
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // =============================================
   // outputs straight from the state register
   assign PKT_VALID     = state_reg.pkt_valid;
   assign PKT_TYPE      = state_reg.pkt_type;
   assign PKT_LAYOUT    = state_reg.pkt_layout;
   assign PKT_PRESENT   = state_reg.pkt_present;
   assign PKT_INDEX     = state_reg.pkt_index;
   assign PKT_BODY      = state_reg.pkt_body;
   assign AUX_OUT_VALID = state_reg.aux_valid;
   assign AUX_OUT_TYPE  = state_reg.aux_type;
   assign AUX_OUT_BODY  = state_reg.aux_body;
   assign OVERRUN       = state_reg.overrun;
endmodule : asp_device
`default_nettype wire

/* File: design/asp_source.sv */
/*
 audio sample packetizer, source end: software loads channel
 words and layout over AHB-Lite and issues qualified beats.
 assumes: one AHB-Lite master, zero wait states, CLK shared.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_source (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   // audio towards the device
   asp_if.source            AUD
);
   // =============================================
   // state
   typedef struct packed {
      logic [7:0][31:0] words;  // channel words, channel 1 low
      logic [4:0]       layout; // layout select
      logic             hold;   // qualifier held high
      logic             qual;   // qualifier register
      logic [255:0]     bus;    // audio bus register
      logic [19:0]      cts;    // time stamp
      logic [19:0]      div;    // divider
      logic [15:0]      sent;   // beats issued by send writes
      logic             wr_pend; // write data phase pending
      logic [7:0]       wr_addr; // its address
      logic [31:0]      rdata;  // read data register
      logic             ready;  // always ready
   } asp_src_state_type;

   asp_src_state_type state_reg;  // registered state
   asp_src_state_type state_next; // its next value

   // =============================================
   // next state: data phase write, then address phase
   always_comb begin
      logic [7:0] a; // address phase offset
      a = HADDR[7:0];
      state_next = state_reg;
      state_next.qual = state_reg.hold;
      state_next.bus  = state_reg.words;
      // data phase of a write: hwdata stands now
      if (state_reg.wr_pend) begin
         state_next.wr_pend = 1'b0;
         if (state_reg.wr_addr >= asp_pkg::REG_WORD0 &&
            state_reg.wr_addr < 8'h40) begin
            // unused lanes are the software's zeros
            state_next.words[state_reg.wr_addr[4:2]] =
               HWDATA;
         end else if (state_reg.wr_addr == asp_pkg::REG_CTRL) begin
            state_next.layout = HWDATA[4:0];
            state_next.hold   = HWDATA[asp_pkg::CTRL_HOLD_BIT];
         end else if (state_reg.wr_addr == asp_pkg::REG_CTS) begin
            state_next.cts = HWDATA[19:0];
         end else if (state_reg.wr_addr == asp_pkg::REG_DIV) begin
            state_next.div = HWDATA[19:0];
         end else if (state_reg.wr_addr == asp_pkg::REG_SEND) begin
            // one qualified beat of the loaded words
            state_next.qual = 1'b1;
            state_next.sent = state_reg.sent + 16'h1;
         end
      end
      // address phase
      if (HSEL && HTRANS[1] && HREADY) begin
         if (HWRITE) begin
            state_next.wr_pend = 1'b1;
            state_next.wr_addr = a;
         end else begin
            // unmapped offsets read as zero
            state_next.rdata = 32'h0000_0000;
            if (a >= asp_pkg::REG_WORD0 && a < 8'h40) begin
               state_next.rdata = state_reg.words[a[4:2]];
            end else if (a == asp_pkg::REG_CTRL) begin
               state_next.rdata[4:0] = state_reg.layout;
               state_next.rdata[asp_pkg::CTRL_HOLD_BIT] =
                  state_reg.hold;
            end else if (a == asp_pkg::REG_CTS) begin
               state_next.rdata[19:0] = state_reg.cts;
            end else if (a == asp_pkg::REG_DIV) begin
               state_next.rdata[19:0] = state_reg.div;
            end else if (a == asp_pkg::REG_STATUS) begin
               state_next.rdata[15:0] = state_reg.sent;
            end
         end
      end
   end

   // =============================================
   // state register
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_reg       <= '0;
         state_reg.div   <= asp_pkg::RST_DIV;
         state_reg.ready <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // =============================================
   // outputs from registers, HRESP tied to zero
   assign HRDATA    = state_reg.rdata;
   assign HREADYOUT = state_reg.ready;
   assign HRESP     = 1'b0;
   assign AUD.audio_data           = state_reg.bus;
   assign AUD.audio_word_qualifier = state_reg.qual;
   assign AUD.layout_select        = state_reg.layout;
   assign AUD.cycle_time_stamp     = state_reg.cts;
   assign AUD.divider              = state_reg.div;
endmodule : asp_source
`default_nettype wire

/* File: verification/asp_checker.sv */
/*
 audio sample packetizer: concurrent checks on the link and outputs.
 assumes: instantiated beside the interface, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_checker (
   // clock and reset
   input wire logic         CLK,
   input wire logic         RST_N,
   // link and configuration
   input wire logic [4:0]   layout_select,
   input wire logic         audio_word_qualifier,
   input wire logic [19:0]  cycle_time_stamp,
   input wire logic [19:0]  divider,
   input wire logic         FRL_OPTION,
   input wire logic         LINK_SLOT,
   input wire logic         VIDEO_SLOT,
   // auxiliary path
   input wire logic         AUX_IN_VALID,
   input wire logic [7:0]   AUX_IN_TYPE,
   input wire logic [255:0] AUX_IN_BODY,
   input wire logic         AUX_OUT_VALID,
   input wire logic [7:0]   AUX_OUT_TYPE,
   input wire logic [255:0] AUX_OUT_BODY,
   // packets out
   input wire logic         PKT_VALID,
   input wire logic [7:0]   PKT_TYPE,
   input wire logic [255:0] PKT_BODY,
   input wire logic         OVERRUN
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // a layout code outside the three supported ones
   wire logic rsv = !(layout_select[3:0] inside {4'h0, 4'h4, 4'h6});
   // =============================================
   // assertions
   type_legal_a: assert property (PKT_VALID |-> PKT_TYPE inside
      {8'h01, 8'h02, 8'h0B, 8'h0E}) else $error("bad packet type");
   slot_drain_a: assert property (PKT_VALID |->
      $past(FRL_OPTION ? VIDEO_SLOT : LINK_SLOT)) else $error("no slot");
   regen_body_a: assert property (PKT_VALID && PKT_TYPE == 8'h01
      |-> PKT_BODY[19:0] == cycle_time_stamp && PKT_BODY[51:32] == divider)
      else $error("regen body wrong");
   aux_valid_a: assert property (AUX_IN_VALID |=> AUX_OUT_VALID)
      else $error("aux packet dropped");
   aux_data_a: assert property (AUX_OUT_VALID |->
      AUX_OUT_TYPE == $past(AUX_IN_TYPE) && AUX_OUT_BODY == $past(AUX_IN_BODY))
      else $error("aux packet altered");
   overrun_cause_a: assert property (OVERRUN |->
      $past(audio_word_qualifier))
      else $error("overrun without beat");
   reserved_quiet_a: assert property (rsv [*8] |->
      !(PKT_VALID && PKT_TYPE != 8'h01)) else $error("reserved packet");
   reset_quiet_a: assert property ($rose(RST_N) |-> !PKT_VALID)
      else $error("packet after reset");
   // =============================================
   // main scenarios reached
   c_regen: cover property (PKT_VALID && PKT_TYPE == 8'h01);
   c_3d:    cover property (PKT_VALID && PKT_TYPE == 8'h0B);
   c_mst:   cover property (PKT_VALID && PKT_TYPE == 8'h0E);
   c_overrun: cover property (OVERRUN);
endmodule : asp_checker
`default_nettype wire

/* File: verification/audio_sample_packetizer_test.sv */
/*
 audio sample packetizer: self-checking bench joining both ends.
 assumes: the source end is driven over AHB-Lite by this bench.
*/
`timescale 1ns/1ps
`default_nettype none
module audio_sample_packetizer_test;
   logic clk, rst_n, hsel, hwrite, hrdy, hresp, frl, lslot, vslot;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic aiv, aov, pv, play, ovr;
   logic [7:0] ait, aot, pt, l_type;
   logic [255:0] aib, aob, pb, l_body;
   logic [3:0] ppr, l_pres;
   logic [1:0] pix, l_idx;
   logic l_lay;
   logic [19:0] e_cts, e_div;
   int errors = 0, check_count = 0, aud_n = 0, ovr_n = 0, acr_n = 0;
   asp_if lnk ();
   asp_source i_asp_source (.CLK(clk), .RST_N(rst_n), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
      .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
      .HRESP(hresp), .AUD(lnk.source));
   asp_device i_asp_device (.CLK(clk), .RST_N(rst_n), .AUD(lnk.device),
      .FRL_OPTION(frl), .LINK_SLOT(lslot), .VIDEO_SLOT(vslot),
      .AUX_IN_VALID(aiv), .AUX_IN_TYPE(ait), .AUX_IN_BODY(aib),
      .PKT_VALID(pv), .PKT_TYPE(pt), .PKT_LAYOUT(play), .PKT_PRESENT(ppr),
      .PKT_INDEX(pix), .PKT_BODY(pb), .AUX_OUT_VALID(aov),
      .AUX_OUT_TYPE(aot), .AUX_OUT_BODY(aob), .OVERRUN(ovr));
   asp_checker i_asp_checker (.CLK(clk), .RST_N(rst_n),
      .layout_select(lnk.layout_select),
      .audio_word_qualifier(lnk.audio_word_qualifier),
      .cycle_time_stamp(lnk.cycle_time_stamp), .divider(lnk.divider),
      .FRL_OPTION(frl), .LINK_SLOT(lslot), .VIDEO_SLOT(vslot),
      .AUX_IN_VALID(aiv), .AUX_IN_TYPE(ait), .AUX_IN_BODY(aib),
      .AUX_OUT_VALID(aov), .AUX_OUT_TYPE(aot), .AUX_OUT_BODY(aob),
      .PKT_VALID(pv), .PKT_TYPE(pt), .PKT_BODY(pb), .OVERRUN(ovr));
   // =============================================
   // clock, verdict and comparison
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic summarize();
      if (errors == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : summarize
   task automatic chk(input string n, input logic [255:0] e, g);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // expected payload type per layout code
   function automatic logic [7:0] exp_type(input logic [3:0] l);
      case (l)
         4'h0: exp_type = 8'h02;
         4'h4: exp_type = 8'h0B;
         4'h6: exp_type = 8'h0E;
         default: exp_type = 8'h00;
      endcase
   endfunction : exp_type
   // first n words present, the rest zero lanes
   function automatic logic [255:0] mk(input int n);
      mk = '0;
      for (int i = 0; i < n; i++) mk[i*32 +: 32] = {1'b1, 31'($urandom)};
   endfunction : mk
   // words whose present flag is low carry nothing into the packet
   function automatic logic [255:0] exp_body(input logic [255:0] v);
      exp_body = v;
      for (int i = 0; i < 8; i++) if (!v[i*32+31]) exp_body[i*32 +: 32] = '0;
   endfunction : exp_body
   // one present bit per channel pair or stream
   function automatic logic [3:0] exp_pres(input logic [255:0] v);
      for (int i = 0; i < 4; i++) exp_pres[i] = v[i*64+31] | v[i*64+63];
   endfunction : exp_pres
   // =============================================
   // AHB-Lite single transfers, waiting on the slave answer
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
      do @(posedge clk); while (hrdy !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      q = hrdata;
      chk("resp", 256'h0, 256'(hresp));
   endtask : ahb
   // load all words, set layout, issue one beat, await its packet
   task automatic beat(input logic [4:0] l, input logic [255:0] v);
      int n0, t;
      for (int i = 0; i < 8; i++) ahb(1'b1, 8'h20 + 8'(i*4), v[i*32 +: 32]);
      ahb(1'b1, asp_pkg::REG_CTRL, {27'h0, l});
      n0 = aud_n;
      ahb(1'b1, asp_pkg::REG_SEND, 32'h1);
      for (t = 0; t < 60 && aud_n == n0; t++) @(posedge clk);
      if (exp_type(l[3:0]) == 8'h00) chk("silent", 256'(n0), 256'(aud_n));
      else begin
         chk("arrived", 256'h1, 256'(aud_n != n0));
         chk("type", 256'(exp_type(l[3:0])), 256'(l_type));
         chk("body", exp_body(v), l_body);
         chk("present", 256'(exp_pres(v)), 256'(l_pres));
      end
   endtask : beat
   // =============================================
   // packet monitor and random slots and aux traffic
   always @(posedge clk) begin
      if (rst_n && pv === 1'b1 && pt === asp_pkg::TYPE_ACR) begin
         chk("cts", 256'(e_cts), 256'(pb[19:0]));
         chk("div", 256'(e_div), 256'(pb[51:32]));
         acr_n++;
      end else if (rst_n && pv === 1'b1) begin
         aud_n++;
         l_type = pt; l_body = pb; l_lay = play; l_idx = pix;
         l_pres = ppr;
      end
      if (rst_n && ovr === 1'b1) ovr_n++;
      lslot <= 1'($urandom); vslot <= 1'($urandom);
      aiv <= 1'($urandom); ait <= 8'($urandom_range(3));
      aib <= {8{32'($urandom)}};
   end
   initial begin
      #(50 * 40000);
      errors++;
      summarize();
   end
   // =============================================
   // main sequence
   initial begin
      logic [255:0] v;
      {rst_n, hsel, hwrite, frl} = '0;
      {haddr, hwdata, htrans} = '0;
      void'($urandom(46));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      ahb(1'b0, asp_pkg::REG_DIV, 32'h0);
      chk("div reset", 256'(asp_pkg::RST_DIV), 256'(q));
      ahb(1'b0, 8'h80, 32'h0);
      chk("unmapped", 256'h0, 256'(q));
      e_cts = 20'($urandom); e_div = 20'h00100; // two samples per regen
      ahb(1'b1, asp_pkg::REG_CTS, {12'h0, e_cts});
      ahb(1'b1, asp_pkg::REG_DIV, {12'h0, e_div});
      for (int r = 0; r < 3; r++) begin
         frl <= 1'(r);
         beat(5'h00, mk(2));
         chk("two ch", 256'h0, 256'(l_lay));
         v = mk(3 + r);
         beat(5'h00, v);
         chk("eight ch", 256'h1, 256'(l_lay));
         v = mk(4 + 2 * (r % 3)) & ~(256'h1 << (32 * r + 31));
         beat(5'h06, v);
         for (int b = 0; b < 3; b++) begin
            beat(b == 0 ? 5'h14 : 5'h04, mk(8));
            chk("part", 256'(b), 256'(l_idx));
         end
         beat(5'(1 + 2 * r), mk(8));
      end
      repeat (20) @(posedge clk);
      // five samples a round, 3D counts its first writes only
      chk("regens", 256'(15 / (e_div >> asp_pkg::ACR_SHIFT)),
         256'(acr_n));
      chk("no overrun", 256'h0, 256'(ovr_n));
      ahb(1'b0, asp_pkg::REG_STATUS, 32'h0);
      chk("sent", 256'h15, 256'(q));
      // qualifier held high: wide packets wait on slots, beats are lost
      ahb(1'b1, asp_pkg::REG_CTRL, 32'h0000_0100);
      repeat (40) @(posedge clk);
      ahb(1'b1, asp_pkg::REG_CTRL, 32'h0);
      chk("overrun", 256'h1, 256'(ovr_n != 0));
      repeat (20) @(posedge clk);
      summarize();
   end
endmodule : audio_sample_packetizer_test
`default_nettype wire
